// [core/bcd_dec_pkg.sv]
// Shared constants and carrier types for the decimal adjust and decrement datapath
package bcd_dec_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int BANK_W = 4;
    localparam logic [3:0] NIB_MAX = 4'h9;
    localparam logic [3:0] NIB_FIX = 4'h6;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [1:0] PHASE_COUNT = 2'h3;
    localparam logic [BANK_W-1:0] ACCESS_BANK = 4'h0;
    localparam logic DEST_ACC = 1'b0;
    localparam logic BANK_ACCESS = 1'b0;

    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_DECADJ = 2'b01,
        OP_DECR = 2'b10
    } op_t;

    typedef enum logic [1:0] {
        PH_DECODE = 2'b00,
        PH_READ = 2'b01,
        PH_PROCESS = 2'b10,
        PH_WRITE = 2'b11
    } phase_t;

    typedef struct packed {
        logic carry;
        logic digitCarry;
        logic negative;
        logic overflow;
        logic zero;
    } flags_t;

    typedef struct packed {
        op_t op;
        logic destSel;
        logic bankSel;
        logic [ADDR_W-1:0] addr;
    } instr_t;

    typedef struct packed {
        logic we;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } memWrite_t;
endpackage : bcd_dec_pkg

// [core/bcd_adjust_unit.sv]
// Combinational packed-BCD adjust of an 8-bit accumulator
`timescale 1ns/1ps
module bcd_adjust_unit
    import bcd_dec_pkg::*;
(
    input wire logic [7:0] accIn,
    input wire logic carryIn,
    input wire logic digitCarryIn,
    output logic [7:0] accOut,
    output logic carryOut,
    output logic digitCarryOut
);
    logic [4:0] lowSum;
    logic [4:0] highSum;
    logic lowFix;
    logic highFix;

    always_comb
    begin
        lowFix = (accIn[3:0] > NIB_MAX) || digitCarryIn;
        highFix = (accIn[7:4] > NIB_MAX) || carryIn;
        lowSum = {1'b0, accIn[3:0]} + (lowFix ? {1'b0, NIB_FIX} : 5'h00);
        // Low nibble overflow ripples into the high digit; the high fix ignores it, so a high 9 becomes A
        highSum = {1'b0, accIn[7:4]} + (highFix ? {1'b0, NIB_FIX} : 5'h00)
            + {4'h0, lowSum[4]};
        accOut = {highSum[3:0], lowSum[3:0]};
        // Carry may become set though it was clear before
        carryOut = carryIn | highSum[4];
        digitCarryOut = digitCarryIn;
    end
endmodule : bcd_adjust_unit

// [core/bcd_adjust_and_decrement.sv]
// Four-phase execution datapath for decimal adjust and operand decrement
// Notes on behaviour
// - Decimal adjust adds 6 to low nibble if above 9 or digit carry set.
// - Decimal adjust adds 6 to high nibble if above 9 or carry set.
// - Decimal adjust turns a BCD-sum accumulator into packed BCD, except a high digit of 9 plus low carry gives A.
// - Decimal adjust changes only carry; digit carry is kept; carry may become set.
// - Decrement subtracts one from the addressed 8-bit memory operand.
// - Destination bit 0 writes accumulator, 1 writes back to operand.
// - Bank bit 0 uses access bank; 1 uses the bank-select pointer.
// - Decrement takes one cycle: decode, read, process, write phases.
`timescale 1ns/1ps
module bcd_adjust_and_decrement
    import bcd_dec_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic start,
    input wire instr_t instr,
    input wire logic [BANK_W-1:0] bankSelectPointer,
    input wire logic [DATA_W-1:0] memRdata,
    output logic [BANK_W-1:0] memBank_q,
    output logic [ADDR_W-1:0] memAddr_q,
    output memWrite_t memWr_q,
    output logic [DATA_W-1:0] acc_q,
    output flags_t flags_q,
    output phase_t phase_q,
    output logic busy_q,
    output logic done_q
);
    instr_t cur_q;
    logic [DATA_W-1:0] operand_q;
    logic [DATA_W-1:0] result_q;
    flags_t resFlags_q;
    logic [7:0] adjAcc;
    logic adjCarry;
    logic adjDc;

    function automatic flags_t decFlags(input logic [7:0] v, input flags_t old);
        flags_t f;
        logic [7:0] r;
        r = v - 8'h01;
        f = old;
        f.carry = (v != 8'h00);
        f.digitCarry = (v[3:0] != 4'h0);
        f.negative = r[7];
        f.overflow = (v == 8'h80);
        f.zero = (r == 8'h00);
        return f;
    endfunction : decFlags

    bcd_adjust_unit uAdj (
        .accIn(acc_q),
        .carryIn(flags_q.carry),
        .digitCarryIn(flags_q.digitCarry),
        .accOut(adjAcc),
        .carryOut(adjCarry),
        .digitCarryOut(adjDc)
    );

    // Phase sequencer: one instruction cycle is four clocks
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            phase_q <= PH_DECODE;
            busy_q <= 1'b0;
            cur_q <= '0;
        end
        else if (!busy_q)
        begin
            if (start && instr.op != OP_NONE)
            begin
                busy_q <= 1'b1;
                cur_q <= instr;
                phase_q <= PH_READ;
            end
        end
        else
        begin
            case (phase_q)
                PH_READ: phase_q <= PH_PROCESS;
                PH_PROCESS: phase_q <= PH_WRITE;
                PH_WRITE:
                begin
                    phase_q <= PH_DECODE;
                    busy_q <= 1'b0;
                end
                default: phase_q <= PH_READ;
            endcase
        end
    end

    // Address and bank presented during the read phase
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            memBank_q <= ACCESS_BANK;
            memAddr_q <= '0;
        end
        else if (!busy_q && start && instr.op == OP_DECR)
        begin
            memAddr_q <= instr.addr;
            memBank_q <= (instr.bankSel == BANK_ACCESS) ? ACCESS_BANK
                : bankSelectPointer;
        end
    end

    // Operand capture and processing
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            operand_q <= '0;
            result_q <= '0;
            resFlags_q <= '0;
        end
        else if (busy_q && phase_q == PH_READ)
        begin
            operand_q <= memRdata;
        end
        else if (busy_q && phase_q == PH_PROCESS)
        begin
            if (cur_q.op == OP_DECR)
            begin
                result_q <= operand_q - 8'h01;
                resFlags_q <= decFlags(operand_q, flags_q);
            end
            else
            begin
                result_q <= adjAcc;
                resFlags_q <= flags_q;
                resFlags_q.carry <= adjCarry;
                resFlags_q.digitCarry <= adjDc;
            end
        end
    end

    // Write-back phase: accumulator and flags
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            acc_q <= ACC_RESET;
            flags_q <= '0;
        end
        else if (busy_q && phase_q == PH_WRITE)
        begin
            flags_q <= resFlags_q;
            if (cur_q.op == OP_DECADJ || cur_q.destSel == DEST_ACC)
            begin
                acc_q <= result_q;
            end
        end
    end

    // Memory write strobe is one clock wide, in the write phase
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            memWr_q <= '0;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= busy_q && phase_q == PH_WRITE;
            memWr_q.we <= busy_q && phase_q == PH_PROCESS && cur_q.op == OP_DECR
                && cur_q.destSel != DEST_ACC;
            memWr_q.bank <= memBank_q;
            memWr_q.addr <= memAddr_q;
            memWr_q.data <= (cur_q.op == OP_DECR) ? operand_q - 8'h01 : 8'h00;
        end
    end

    sequence decrRun_s;
        !busy_q && start && instr.op == OP_DECR;
    endsequence

    phase_seq_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (!busy_q && start && instr.op != OP_NONE) |=> phase_q == PH_READ ##1
        phase_q == PH_PROCESS ##1 phase_q == PH_WRITE ##1 !busy_q)
        else $error("instruction did not take four phases");

    done_pulse_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (!busy_q && start && instr.op != OP_NONE) |=> ##3 done_q)
        else $error("done not raised at end of cycle");

    bank_access_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (decrRun_s and instr.bankSel == BANK_ACCESS) |=> memBank_q == ACCESS_BANK)
        else $error("access bank not selected");

    bank_pointer_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (decrRun_s and instr.bankSel != BANK_ACCESS)
        |=> memBank_q == $past(bankSelectPointer))
        else $error("bank pointer not used");

    decr_value_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (busy_q && phase_q == PH_PROCESS && cur_q.op == OP_DECR)
        |=> result_q == $past(operand_q) - 8'h01)
        else $error("decrement result wrong");

    dest_mem_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (decrRun_s and instr.destSel != DEST_ACC) |=> ##2 memWr_q.we ##1 !memWr_q.we)
        else $error("write-back strobe missing");

    dest_acc_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (decrRun_s and instr.destSel == DEST_ACC) |=> !memWr_q.we [*4])
        else $error("memory written for accumulator destination");

    zero_flag_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (busy_q && phase_q == PH_WRITE && cur_q.op == OP_DECR)
        |=> flags_q.zero == ($past(result_q) == 8'h00))
        else $error("zero flag wrong after decrement");

    adj_nibble_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (busy_q && phase_q == PH_PROCESS && cur_q.op == OP_DECADJ
        && acc_q[3:0] <= NIB_MAX && !flags_q.digitCarry)
        |=> result_q[3:0] == $past(acc_q[3:0]))
        else $error("low nibble changed without cause");

    adj_keepdc_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (busy_q && phase_q == PH_WRITE && cur_q.op == OP_DECADJ)
        |=> flags_q.digitCarry == $past(flags_q.digitCarry)
        && flags_q.zero == $past(flags_q.zero))
        else $error("adjust changed a flag it must keep");
endmodule : bcd_adjust_and_decrement

// [bench/test_bcd_adjust_and_decrement.sv]
// Directed testbench for the decimal adjust and decrement datapath
`timescale 1ns/1ps
module test_bcd_adjust_and_decrement
    import bcd_dec_pkg::*;
;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic start = 1'b0;
    instr_t instr = '0;
    logic [BANK_W-1:0] bankSelectPointer = '0;
    logic [DATA_W-1:0] memRdata = '0;
    logic [BANK_W-1:0] memBank_q;
    logic [ADDR_W-1:0] memAddr_q;
    memWrite_t memWr_q;
    logic [DATA_W-1:0] acc_q;
    flags_t flags_q;
    phase_t phase_q;
    logic busy_q;
    logic done_q;
    int errorCnt = 0;
    int nChecks = 0;
    logic [7:0] operands [3] = '{8'h00, 8'hA6, 8'h20};
    logic [4:0] decFlags [3] = '{5'h04, 5'h1C, 5'h10};
    logic [7:0] adjAcc [3] = '{8'h65, 8'h0B, 8'h85};
    logic [4:0] adjFlags [3] = '{5'h14, 5'h1C, 5'h10};

    always #50 mclk = ~mclk;

    bcd_adjust_and_decrement i_dut (
        .mclk(mclk), .arst_n(arst_n), .start(start), .instr(instr),
        .bankSelectPointer(bankSelectPointer), .memRdata(memRdata),
        .memBank_q(memBank_q), .memAddr_q(memAddr_q), .memWr_q(memWr_q),
        .acc_q(acc_q), .flags_q(flags_q), .phase_q(phase_q),
        .busy_q(busy_q), .done_q(done_q)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        nChecks++;
        if (seen !== expected)
        begin
            errorCnt++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expected);
        end
    endtask : check

    task automatic end_of_test();
        $display("Checks: %0d, mismatches: %0d", nChecks, errorCnt);
        if (errorCnt == 0 && nChecks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    // Issues one instruction at a falling edge and follows it through its four phases
    task automatic run(input op_t op, input logic dst, input logic bnk, input logic [7:0] addr,
        input logic [3:0] ptr, input logic [7:0] rd, input logic weExp);
        logic [3:0] bankExp;
        bankExp = bnk ? ptr : ACCESS_BANK;
        start = 1'b1;
        instr = '{op: op, destSel: dst, bankSel: bnk, addr: addr};
        bankSelectPointer = ptr;
        memRdata = rd;
        @(negedge mclk);
        check(16'({busy_q, phase_q}), 16'h0005);
        if (op == OP_DECR)
            check(16'({memBank_q, memAddr_q}), 16'({bankExp, addr}));
        // Start stays high with altered fields: a busy datapath must not take them
        instr.addr = ~addr;
        bankSelectPointer = ~ptr;
        @(negedge mclk);
        check(16'(phase_q), 16'h0002);
        @(negedge mclk);
        check(16'({phase_q, memWr_q.we}), 16'({2'h3, weExp}));
        if (op == OP_DECR)
            check(16'(memAddr_q), 16'(addr));
        if (weExp)
        begin
            check(16'({memWr_q.bank, memWr_q.addr}), 16'({bankExp, addr}));
            check(16'(memWr_q.data), 16'(8'(rd - 8'h01)));
        end
        start = 1'b0;
        @(negedge mclk);
        check(16'({done_q, busy_q, memWr_q.we, phase_q}), 16'h0010);
    endtask : run

    initial
    begin
        #(100 * 2000);
        errorCnt++;
        end_of_test();
    end

    initial
    begin
        repeat (8) @(negedge mclk);
        check(16'({acc_q, flags_q, busy_q, done_q, memWr_q.we}), 16'h0000);
        arst_n = 1'b1;
        @(negedge mclk);
        // Write back to memory through the pointer bank; overflow on the 0x80 operand
        run(OP_DECR, 1'b1, 1'b1, 8'h3C, 4'h5, 8'h80, 1'b1);
        check(16'(acc_q), 16'h0000);
        check(16'(flags_q), 16'h0012);
        // Carry set, low digit small: only the high digit is corrected
        run(OP_DECADJ, 1'b1, 1'b1, 8'h00, 4'h0, 8'h00, 1'b0);
        check(16'({acc_q, flags_q}), 16'h0C12);
        // Result to the accumulator through the access bank, zero result
        run(OP_DECR, DEST_ACC, BANK_ACCESS, 8'hFF, 4'hA, 8'h01, 1'b0);
        check(16'(acc_q), 16'h0000);
        check(16'(flags_q), 16'h0019);
        // An empty opcode is not taken
        start = 1'b1;
        instr = '{op: OP_NONE, destSel: 1'b0, bankSel: 1'b0, addr: 8'h11};
        repeat (2) @(negedge mclk);
        check(16'({busy_q, done_q, phase_q}), 16'h0000);
        start = 1'b0;
        @(negedge mclk);
        // Load the accumulator by decrement, then adjust it
        for (int i = 0; i < 3; i++)
        begin
            run(OP_DECR, DEST_ACC, 1'b1, 8'h40, 4'h3, operands[i], 1'b0);
            check(16'(acc_q), 16'(8'(operands[i] - 8'h01)));
            check(16'(flags_q), 16'(decFlags[i]));
            run(OP_DECADJ, 1'b1, 1'b1, 8'h00, 4'h0, 8'h00, 1'b0);
            check(16'(acc_q), 16'(adjAcc[i]));
            check(16'(flags_q), 16'(adjFlags[i]));
        end
        end_of_test();
    end
endmodule : test_bcd_adjust_and_decrement
